// ### rtl/clock_synth_pkg.sv
package clock_synth_pkg;

  // Configuration storage
  localparam int CFG_W = 28;
  localparam int NUM_CFG = 3;
  localparam int IDX_W = 2;
  localparam logic [IDX_W-1:0] LAST_IDX = 2'h2;

  // APB map
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CFG0 = 8'h00;
  localparam logic [APB_AW-1:0] OFS_CFG1 = 8'h04;
  localparam logic [APB_AW-1:0] OFS_CFG2 = 8'h08;
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h10;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Register 0 fields
  localparam int CODE_W = 4;
  localparam int CH0_LSB = 0;
  localparam int CH1_LSB = 4;
  localparam int REFDIV_LSB = 8;
  localparam int AUX_SEL_BIT = 12;
  localparam int BUF_EN0_BIT = 13;
  localparam int BUF_EN1_BIT = 14;
  // Register 1 fields
  localparam int INDIV_LSB = 0;
  localparam int INDIV_W = 8;
  localparam int FBDIV_LSB = 8;
  localparam int FBDIV_W = 10;
  localparam int PRESC_LSB = 18;
  localparam int PRESC_W = 2;
  localparam int VCO_SEL_BIT = 20;
  // Register 2 fields
  localparam int PWR_SHADOW_BIT = 7;
  localparam int SYNC_BIT = 8;

  // CTRL and STATUS bits
  localparam int CTRL_STORE_BIT = 0;
  localparam int STAT_LOAD_BIT = 0;
  localparam int STAT_STORE_BIT = 1;
  localparam int STAT_PDOWN_BIT = 2;
  localparam int STAT_SYNC_BIT = 3;
  localparam int STAT_BAD0_BIT = 4;
  localparam int STAT_BAD1_BIT = 5;
  localparam int STAT_ACTIVE_BIT = 6;

  // Nonvolatile defaults at first power
  localparam logic [CFG_W-1:0] NV_DEFAULT0 = 28'h000_6021;
  localparam logic [CFG_W-1:0] NV_DEFAULT1 = 28'h000_2804;
  localparam logic [CFG_W-1:0] NV_DEFAULT2 = 28'h000_0180;

  // Serial link word: data above, address in low nibble
  localparam int LINK_W = 32;
  localparam int LINK_CNT_W = 5;
  localparam logic [LINK_CNT_W-1:0] LINK_LAST_BIT = 5'h1F;
  localparam int LINK_AW = 4;
  localparam logic [LINK_AW-1:0] LINK_CMD_STORE = 4'h3;

  localparam int RATIO_W = 6;
  localparam logic [RATIO_W-1:0] RATIO_NONE = 6'h00;
  localparam logic [RATIO_W-1:0] RATIO_ONE = 6'h01;

  typedef enum logic [3:0] {
    ST_LOAD = 4'b0001,
    ST_ACTIVE = 4'b0010,
    ST_STORE = 4'b0100,
    ST_PDOWN = 4'b1000
  } state_t;

  typedef struct packed {
    logic [CODE_W-1:0] ch0_code;
    logic [CODE_W-1:0] ch1_code;
    logic [CODE_W-1:0] ref_div;
    logic aux_sel;
    logic [INDIV_W-1:0] in_div;
    logic [FBDIV_W-1:0] fb_div;
    logic [PRESC_W-1:0] prescale;
    logic [1:0] vco_en;
  } synth_cfg_t;

  // Output divider code to ratio; zero marks a reserved code
  function automatic logic [RATIO_W-1:0] ratio_of(input logic [CODE_W-1:0] code);
    logic [RATIO_W-1:0] r;
    r = RATIO_NONE;
    unique case (code)
      4'h0: r = 6'd1;
      4'h1: r = 6'd2;
      4'h2: r = 6'd3;
      4'h3: r = 6'd4;
      4'h4: r = 6'd5;
      4'h5: r = 6'd8;
      4'h6: r = 6'd10;
      4'h7: r = 6'd12;
      4'h8: r = 6'd16;
      4'h9: r = 6'd20;
      4'hA: r = 6'd24;
      4'hB: r = 6'd32;
      default: r = RATIO_NONE;
    endcase
    return r;
  endfunction

endpackage

// ### rtl/channel_divider_module.sv
`timescale 1ns/1ps
`default_nettype none
module channel_divider_module
  import clock_synth_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic hold,
  input wire logic [CODE_W-1:0] code,
  // Divided tick
  output logic tick_q
);

  logic [RATIO_W-1:0] cnt_q;
  logic [RATIO_W-1:0] cnt_d;
  logic tick_d;
  wire logic [RATIO_W-1:0] ratio = ratio_of(code);
  wire logic stopped = hold || (ratio == RATIO_NONE);
  wire logic wrap = (cnt_q == ratio - RATIO_ONE);

  always_comb
  begin
    cnt_d = RATIO_NONE;
    tick_d = 1'b0;
    if (stopped)
    begin
      cnt_d = RATIO_NONE;
      tick_d = 1'b0;
    end
    else if (ratio == RATIO_ONE)
    begin
      // Divider bypassed
      tick_d = 1'b1;
    end
    else if (wrap)
    begin
      tick_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + RATIO_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= RATIO_NONE;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule // channel_divider_module
`default_nettype wire

// ### rtl/clock_synth_config_control.sv
// What this block does
// - Three 28-bit RAM registers define configuration
// - Power-up copies nonvolatile image into RAM
// - Serial writes overwrite RAM registers after power-up
// - Host request copies RAM into nonvolatile memory
// - Each channel's 4-bit code sits in register 0
// - Twelve ratios from 1 to 32 supported (1, 2, 3, 4, 5, 8, 10, 12, 16, 20, 24, 32); ratio 1 bypasses
// - At most one of two oscillators enabled; none while loading or powered down
// - Output frequency follows divider chain relation
// - Auxiliary input forces reference divide to one
// - Primary reference divided before input selector
// - Power-down pin resets; release reloads image
// - Shadow power-down bit; release skips reload
// - Sync low holds dividers, disables outputs
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module clock_synth_config_control
  import clock_synth_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power-down pin
  input wire logic power_down_n,
  // Serial link
  input wire logic link_sclk,
  input wire logic serial_latch_enable,
  input wire logic serial_data_in,
  // Synthesizer controls
  output synth_cfg_t synth_cfg,
  output logic [1:0] out_buf_en,
  output logic [1:0] div_tick
);

  // Link domain: shift in 32-bit frames while latch enable is low
  wire logic link_rst_n = presetn & power_down_n;
  logic [LINK_W-1:0] lshift_q;
  logic [LINK_CNT_W-1:0] lcnt_q;
  logic [LINK_W-1:0] lword_q;
  logic ltog_q;
  wire logic [LINK_W-1:0] lshift_next = {lshift_q[LINK_W-2:0], serial_data_in};
  wire logic lframe_done = !serial_latch_enable && (lcnt_q == LINK_LAST_BIT);

  always_ff @(posedge link_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      lshift_q <= ZERO_WORD;
      lcnt_q <= '0;
      lword_q <= ZERO_WORD;
      ltog_q <= 1'b0;
    end
    else if (serial_latch_enable)
    begin
      lcnt_q <= '0;
    end
    else
    begin
      lshift_q <= lshift_next;
      lcnt_q <= lcnt_q + 5'h01;
      if (lframe_done)
      begin
        lword_q <= lshift_next;
        ltog_q <= ~ltog_q;
      end
    end
  end

  // Crossing into pclk: toggle handshake, word held stable until next frame
  logic tog_meta_q;
  logic tog_sync_q;
  logic tog_seen_q;
  logic pwr_meta_q;
  logic pwr_sync_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tog_meta_q <= 1'b0;
      tog_sync_q <= 1'b0;
      tog_seen_q <= 1'b0;
      pwr_meta_q <= 1'b0;
      pwr_sync_q <= 1'b0;
    end
    else
    begin
      tog_meta_q <= ltog_q;
      tog_sync_q <= tog_meta_q;
      tog_seen_q <= tog_sync_q;
      pwr_meta_q <= power_down_n;
      pwr_sync_q <= pwr_meta_q;
    end
  end

  wire logic link_new = tog_sync_q ^ tog_seen_q;
  wire logic [LINK_AW-1:0] link_addr = lword_q[LINK_AW-1:0];
  wire logic [CFG_W-1:0] link_data = lword_q[LINK_W-1:LINK_AW];

  // State and storage
  state_t state_q;
  state_t state_d;
  logic [IDX_W-1:0] idx_q;
  logic reload_q;
  logic store_pend_q;
  logic [CFG_W-1:0] cfg_q [NUM_CFG];
  logic [CFG_W-1:0] nv_q [NUM_CFG];

  wire logic st_load = (state_q == ST_LOAD);
  wire logic st_active = (state_q == ST_ACTIVE);
  wire logic st_store = (state_q == ST_STORE);
  wire logic st_pdown = (state_q == ST_PDOWN);
  wire logic idx_last = (idx_q == LAST_IDX);
  wire logic shadow_pwr_n = cfg_q[2][PWR_SHADOW_BIT];
  wire logic sync_bit = cfg_q[2][SYNC_BIT];
  wire logic cfg_writable = st_active || st_pdown;

  // APB decode
  wire logic apb_setup = psel && !penable;
  wire logic apb_done = psel && penable && pready;
  wire logic sel_cfg0 = (paddr == OFS_CFG0);
  wire logic sel_cfg1 = (paddr == OFS_CFG1);
  wire logic sel_cfg2 = (paddr == OFS_CFG2);
  wire logic sel_ctrl = (paddr == OFS_CTRL);
  wire logic sel_status = (paddr == OFS_STATUS);
  wire logic addr_ok = sel_cfg0 || sel_cfg1 || sel_cfg2 || sel_ctrl || sel_status;
  wire logic apb_wr = apb_done && pwrite && !pslverr;
  wire logic [NUM_CFG-1:0] apb_wr_cfg = {sel_cfg2, sel_cfg1, sel_cfg0} & {NUM_CFG{apb_wr && cfg_writable}};
  wire logic [NUM_CFG-1:0] link_wr_cfg =
    {link_addr == 4'h2, link_addr == 4'h1, link_addr == 4'h0} & {NUM_CFG{link_new && cfg_writable}};
  wire logic store_req = (apb_wr && sel_ctrl && pwdata[CTRL_STORE_BIT])
                      || (link_new && link_addr == LINK_CMD_STORE);

  wire logic [RATIO_W-1:0] ch0_ratio = ratio_of(cfg_q[0][CH0_LSB +: CODE_W]);
  wire logic [RATIO_W-1:0] ch1_ratio = ratio_of(cfg_q[0][CH1_LSB +: CODE_W]);
  wire logic bad0 = (ch0_ratio == RATIO_NONE);
  wire logic bad1 = (ch1_ratio == RATIO_NONE);

  wire logic [31:0] status_word = {25'h000_0000, st_active, bad1, bad0, sync_bit, st_pdown, st_store, st_load};
  wire logic [31:0] rd_mux =
      sel_cfg0 ? {4'h0, cfg_q[0]} :
      sel_cfg1 ? {4'h0, cfg_q[1]} :
      sel_cfg2 ? {4'h0, cfg_q[2]} :
      sel_ctrl ? {31'h0000_0000, store_pend_q} :
      sel_status ? status_word : ZERO_WORD;

  // Next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_LOAD:
      begin
        if (idx_last)
        begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE:
      begin
        if (!shadow_pwr_n)
        begin
          state_d = ST_PDOWN;
        end
        else if (store_pend_q)
        begin
          state_d = ST_STORE;
        end
      end
      ST_STORE:
      begin
        if (idx_last)
        begin
          state_d = ST_ACTIVE;
        end
      end
      ST_PDOWN:
      begin
        if (pwr_sync_q && reload_q)
        begin
          state_d = ST_LOAD;
        end
        else if (pwr_sync_q && shadow_pwr_n)
        begin
          state_d = ST_ACTIVE;
        end
      end
      default: state_d = ST_PDOWN;
    endcase
    if (!pwr_sync_q)
    begin
      state_d = ST_PDOWN;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_LOAD;
      idx_q <= '0;
      reload_q <= 1'b0;
      store_pend_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= (state_d != state_q || st_active || st_pdown) ? '0 : idx_q + 2'h1;
      // Pin low schedules a reload; shadow bit alone never does
      reload_q <= !pwr_sync_q || (reload_q && !st_load);
      // A new request wins over the clear on entry to store
      store_pend_q <= store_req || (store_pend_q && !(st_active && state_d == ST_STORE));
    end
  end

  // RAM configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CFG; i++)
      begin
        cfg_q[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CFG; i++)
      begin
        if (st_load && idx_q == IDX_W'(i))
        begin
          cfg_q[i] <= nv_q[i];
        end
        else if (apb_wr_cfg[i])
        begin
          cfg_q[i] <= pwdata[CFG_W-1:0];
        end
        else if (link_wr_cfg[i])
        begin
          cfg_q[i] <= link_data;
        end
      end
    end
  end

  // Nonvolatile image
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_q[0] <= NV_DEFAULT0;
      nv_q[1] <= NV_DEFAULT1;
      nv_q[2] <= NV_DEFAULT2;
    end
    else if (st_store)
    begin
      nv_q[idx_q] <= cfg_q[idx_q];
    end
  end

  // APB answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= ZERO_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      prdata <= (apb_setup && !pwrite) ? rd_mux : ZERO_WORD;
    end
  end

  // Configuration outputs
  wire logic hold_div = !st_active || !sync_bit;
  synth_cfg_t cfg_d;

  always_comb
  begin
    cfg_d.ch0_code = cfg_q[0][CH0_LSB +: CODE_W];
    cfg_d.ch1_code = cfg_q[0][CH1_LSB +: CODE_W];
    // Primary reference divider; bypassed when auxiliary input selected
    cfg_d.ref_div = cfg_q[0][AUX_SEL_BIT] ? '0 : cfg_q[0][REFDIV_LSB +: CODE_W];
    cfg_d.aux_sel = cfg_q[0][AUX_SEL_BIT];
    cfg_d.in_div = cfg_q[1][INDIV_LSB +: INDIV_W];
    cfg_d.fb_div = cfg_q[1][FBDIV_LSB +: FBDIV_W];
    cfg_d.prescale = cfg_q[1][PRESC_LSB +: PRESC_W];
    cfg_d.vco_en = '0;
    if (!st_pdown && !st_load)
    begin
      cfg_d.vco_en = cfg_q[1][VCO_SEL_BIT] ? 2'b10 : 2'b01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      synth_cfg <= '0;
      out_buf_en <= 2'b00;
    end
    else
    begin
      synth_cfg <= cfg_d;
      out_buf_en <= {cfg_q[0][BUF_EN1_BIT] && !bad1, cfg_q[0][BUF_EN0_BIT] && !bad0} & {2{!hold_div}};
    end
  end

  channel_divider_module u_div0 (
    .pclk(pclk),
    .presetn(presetn),
    .hold(hold_div),
    .code(cfg_q[0][CH0_LSB +: CODE_W]),
    .tick_q(div_tick[0])
  );

  channel_divider_module u_div1 (
    .pclk(pclk),
    .presetn(presetn),
    .hold(hold_div),
    .code(cfg_q[0][CH1_LSB +: CODE_W]),
    .tick_q(div_tick[1])
  );

endmodule // clock_synth_config_control
`default_nettype wire

// ### verif/clock_synth_config_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module clock_synth_config_control_props
  import clock_synth_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and outputs
  input wire logic power_down_n,
  input wire synth_cfg_t synth_cfg,
  input wire logic [1:0] out_buf_en,
  input wire logic [1:0] div_tick
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_READY: assert property (psel && !penable |=> pready) else $error("ready late");
  AST_ONE: assert property (pready |=> !pready) else $error("ready long");
  AST_ERR: assert property (pslverr |-> pready) else $error("stray error");
  AST_RD0: assert property (!pready |-> prdata == ZERO_WORD) else $error("stray data");
  AST_VCO: assert property ($onehot0(synth_cfg.vco_en)) else $error("two vcos");
  AST_AUX: assert property (synth_cfg.aux_sel |-> synth_cfg.ref_div == 4'h0) else $error("ref div");
  AST_PD: assert property ($fell(power_down_n) |-> ##[1:5] (synth_cfg.vco_en == 2'h0 && out_buf_en == 2'h0))
    else $error("no shutdown");
  AST_BYP: assert property ((out_buf_en[1] && synth_cfg.ch1_code == 4'h0) [*3] |-> div_tick[1])
    else $error("no bypass");
  // A switch to the bypass code may legally raise the tick again at once
  AST_PULSE: assert property ((synth_cfg.ch1_code != 4'h0) [*4] ##0 div_tick[1] ##1 (synth_cfg.ch1_code != 4'h0)
    |-> !div_tick[1])
    else $error("long tick");
  AST_RSV: assert property ((synth_cfg.ch0_code > 4'hB) [*3] |-> !out_buf_en[0] && !div_tick[0])
    else $error("reserved on");
endmodule // clock_synth_config_control_props

bind clock_synth_config_control clock_synth_config_control_props i_clock_synth_config_control_props (
  .pclk,
  .presetn,
  .psel,
  .penable,
  .prdata,
  .pready,
  .pslverr,
  .power_down_n,
  .synth_cfg,
  .out_buf_en,
  .div_tick
);
`default_nettype wire

// ### verif/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
  import clock_synth_pkg::*;
(
  // Serial link
  output logic link_sclk,
  output logic serial_latch_enable,
  output logic serial_data_in
);
  logic [LINK_W-1:0] word_q;
  initial
  begin
    link_sclk = 1'b0;
    serial_latch_enable = 1'b1;
    serial_data_in = 1'b0;
  end
  // Clock runs only inside a frame; stall stretches low time
  task automatic send(input logic [LINK_AW-1:0] addr, input logic [CFG_W-1:0] data, input int stall);
    word_q = {data, addr};
    #13 serial_latch_enable = 1'b0;
    for (int i = LINK_W - 1; i >= 0; i--)
    begin
      serial_data_in = word_q[i];
      #40 link_sclk = 1'b1;
      #40 link_sclk = 1'b0;
      #(stall);
    end
    serial_latch_enable = 1'b1;
    serial_data_in = ~word_q[0];
  endtask
endmodule // serial_host_model
`default_nettype wire

// ### verif/test_clock_synth_config_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_clock_synth_config_control
  import clock_synth_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, power_down_n, er;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr;
  wire logic sclk, sle, sdi;
  synth_cfg_t synth_cfg;
  logic [1:0] out_buf_en, div_tick;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  int rat [12] = '{1, 2, 3, 4, 5, 8, 10, 12, 16, 20, 24, 32};

  clock_synth_config_control i_clock_synth_config_control (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .power_down_n, .link_sclk(sclk), .serial_latch_enable(sle), .serial_data_in(sdi),
    .synth_cfg, .out_buf_en, .div_tick
  );
  serial_host_model i_serial_host_model (
    .link_sclk(sclk),
    .serial_latch_enable(sle),
    .serial_data_in(sdi)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the rising edge; the wait ends when pready is high, and has no limit of its own beyond the timeout
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_defaults();
    apb(1'b0, OFS_CFG0, ZERO_WORD);
    chk(rd, {4'h0, NV_DEFAULT0});
    apb(1'b0, OFS_CFG1, ZERO_WORD);
    chk(rd, {4'h0, NV_DEFAULT1});
    apb(1'b0, 8'h14, ZERO_WORD);
    chk(rd | {31'h0, er}, 32'h0000_0001);
  endtask

  task automatic t_ratios();
    for (int c = 0; c < 12; c++)
    begin
      apb(1'b1, OFS_CFG0, 32'h0000_600C | 32'(c << 4));
      repeat (8) @(negedge pclk);
      chk(32'(out_buf_en), 32'h0000_0002);
      for (n = 0; n < 40 && div_tick[1] !== 1'b1; n++) @(negedge pclk);
      n = 0;
      do
      begin
        @(negedge pclk);
        n++;
      end
      while (div_tick[1] !== 1'b1 && n < 40);
      chk(32'(n), 32'(rat[c]));
    end
  endtask

  task automatic t_sync();
    apb(1'b1, OFS_CFG0, 32'h0000_6011);
    apb(1'b1, OFS_CFG2, 32'h0000_0080);
    repeat (4) @(negedge pclk);
    chk(32'({out_buf_en, div_tick}), ZERO_WORD);
    apb(1'b1, OFS_CFG2, 32'h0000_0180);
    n = 0;
    repeat (20)
    begin
      @(negedge pclk);
      n += 32'(div_tick[0] !== div_tick[1]);
    end
    chk(32'(n) | 32'(out_buf_en), 32'h0000_0003);
    // Channel 0 unused: host turns its buffer off
    apb(1'b1, OFS_CFG0, 32'h0000_4311);
    repeat (4) @(negedge pclk);
    chk(32'({synth_cfg.ref_div, out_buf_en}), 32'h0000_000E);
  endtask

  task automatic t_serial();
    logic [1:0] v0;
    v0 = synth_cfg.vco_en;
    i_serial_host_model.send(4'h1, NV_DEFAULT1 ^ 28'h010_0000, 0);
    repeat (10) @(negedge pclk);
    apb(1'b0, OFS_CFG1, ZERO_WORD);
    chk(rd, {4'h0, NV_DEFAULT1 ^ 28'h010_0000});
    chk(32'(synth_cfg.vco_en ^ v0), 32'h0000_0003);
    chk(32'({synth_cfg.prescale, synth_cfg.fb_div, synth_cfg.in_div}), 32'h0000_2804);
    i_serial_host_model.send(4'h0, 28'h000_7521, 200);
    repeat (10) @(negedge pclk);
    chk(32'({synth_cfg.aux_sel, synth_cfg.ref_div, synth_cfg.ch0_code}), 32'h0000_0101);
  endtask

  task automatic t_store();
    apb(1'b1, OFS_CFG0, 32'h0000_6055);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    rd[STAT_STORE_BIT] = 1'b1;
    for (n = 0; n < 20 && rd[STAT_STORE_BIT] !== 1'b0; n++) apb(1'b0, OFS_STATUS, ZERO_WORD);
    apb(1'b1, OFS_CFG0, 32'h0000_6077);
    @(posedge pclk);
    power_down_n <= 1'b0;
    repeat (6) @(posedge pclk);
    power_down_n <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_CFG0, ZERO_WORD);
    chk(rd, 32'h0000_6055);
    apb(1'b1, OFS_CFG0, 32'h0000_6077);
    apb(1'b1, OFS_CFG2, 32'h0000_0100);
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    chk(rd & 32'h0000_0004, 32'h0000_0004);
    apb(1'b1, OFS_CFG2, 32'h0000_0180);
    repeat (10) @(posedge pclk);
    apb(1'b0, OFS_CFG0, ZERO_WORD);
    chk(rd, 32'h0000_6077);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = ZERO_WORD;
    power_down_n = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    t_defaults();
    t_ratios();
    t_sync();
    t_serial();
    t_store();
    end_of_test();
  end
endmodule // test_clock_synth_config_control
`default_nettype wire
